// File: hdl/pcw_watchdog.sv
`timescale 1ns/1ps
// Behaviour
// - relay held energised while kick output toggles within every 200 ms
// - kick stops toggling in time: relay released, lamp off
// - lamp lit exactly while relay closed
// - first command with parameter one or two arms soft watchdog, later ones re-trigger expiry timer
// - parameter zero disarms soft watchdog; no expiry afterwards
// - parameter one arms; expiry after 200 ms gives cold start
// - parameter two arms; expiry runs power-fail handler, then cold start
// - each handler call logged with cause soft expiry; supply fault logged with its own cause except in the cycle a handler call is logged, no handler call
// - status input reads one while relay is on
module pcw_watchdog (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              kick,
   input  wire pcw_pkg::pcw_cmd_t soft_cmd,
   input  wire logic              supply_fault,
   input  wire logic              handler_done,
   output logic                   relay_on,
   output logic                   watchdog_lamp,
   output logic                   relay_status,
   output logic                   soft_armed,
   output logic                   handler_req,
   output logic                   cold_start,
   output pcw_pkg::pcw_hist_t     hist
);

   logic                    kick_s1;
   logic                    kick_s2;
   logic                    kick_s3;
   logic [2:0]              kick_warm;
   logic [pcw_pkg::CNT_W-1:0] kick_cnt;
   logic [pcw_pkg::CNT_W-1:0] soft_cnt;
   logic                    fault_s1;
   logic                    fault_s2;
   logic                    fault_s3;
   logic                    soft_pfh;
   pcw_pkg::pcw_state_t     state;
   pcw_pkg::pcw_state_t     next_state;

   // decode
   wire kick_edge   = kick_warm[2] && (kick_s2 ^ kick_s3); // only once both copies are real
   wire kick_expire = (kick_cnt == pcw_pkg::CNT_W'(pcw_pkg::KICK_LIMIT_CYC));
   wire cmd_off     = soft_cmd.valid && (soft_cmd.param == pcw_pkg::SOFT_PARAM_OFF);
   wire cmd_arm     = soft_cmd.valid && ((soft_cmd.param == pcw_pkg::SOFT_PARAM_COLD)
                      || (soft_cmd.param == pcw_pkg::SOFT_PARAM_PFH));
   // a command in the expiry cycle wins over the expiry
   wire soft_expire = (state == pcw_pkg::PCW_ARMED) && !soft_cmd.valid
                      && (soft_cnt == pcw_pkg::CNT_W'(pcw_pkg::SOFT_LIMIT_CYC));
   wire fault_rise  = fault_s2 && !fault_s3;

   // kick pin and supply fault come from outside: two flops first
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         kick_s1  <= 1'b0;
         kick_s2  <= 1'b0;
         kick_s3  <= 1'b0;
         fault_s1 <= 1'b0;
         fault_s2 <= 1'b0;
         fault_s3 <= 1'b0;
      end else begin
         kick_s1  <= kick;
         kick_s2  <= kick_s1;
         kick_s3  <= kick_s2;
         fault_s1 <= supply_fault;
         fault_s2 <= fault_s1;
         fault_s3 <= fault_s2;
      end
   end

   // the first samples after reset are not the pin yet; a pin held high
   // through reset would otherwise look like an edge and close the relay
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         kick_warm <= '0;
      end else begin
         kick_warm <= {kick_warm[1:0], 1'b1};
      end
   end

   // hardware watchdog; relay starts released until the first edge
   // counter parks at the limit so it cannot wrap back into the closed window
   // edge reloads counter
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         kick_cnt <= pcw_pkg::CNT_W'(pcw_pkg::KICK_LIMIT_CYC);
      end else if (kick_edge) begin
         kick_cnt <= '0;
      end else if (!kick_expire) begin
         kick_cnt <= kick_cnt + 1'b1;
      end
   end

   // lamp and status are flops of their own so each pin comes off a register
   // relay, lamp, status
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         relay_on      <= 1'b0;
         watchdog_lamp <= 1'b0;
         relay_status  <= 1'b0;
      end else begin
         relay_on      <= kick_edge || !kick_expire;
         watchdog_lamp <= kick_edge || !kick_expire;
         relay_status  <= kick_edge || !kick_expire;
      end
   end

   // soft watchdog next state
   // arm, disarm, expiry path
   always_comb begin
      next_state = state;
      case (state)
         pcw_pkg::PCW_IDLE: begin
            if (cmd_arm) next_state = pcw_pkg::PCW_ARMED;
         end
         pcw_pkg::PCW_ARMED: begin
            if (cmd_off) next_state = pcw_pkg::PCW_IDLE;
            else if (soft_expire && soft_pfh) next_state = pcw_pkg::PCW_HANDLER;
            else if (soft_expire) next_state = pcw_pkg::PCW_RESTART;
         end
         pcw_pkg::PCW_HANDLER: begin
            if (handler_done) next_state = pcw_pkg::PCW_RESTART;
         end
         default: begin
            next_state = pcw_pkg::PCW_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state    <= pcw_pkg::PCW_IDLE;
         soft_cnt <= '0;
         soft_pfh <= 1'b0;
      end else begin
         state <= next_state;
         if (cmd_arm || state != pcw_pkg::PCW_ARMED) begin
            soft_cnt <= '0;
         end else if (soft_cnt != pcw_pkg::CNT_W'(pcw_pkg::SOFT_LIMIT_CYC)) begin
            soft_cnt <= soft_cnt + 1'b1;
         end
         if (cmd_arm) soft_pfh <= (soft_cmd.param == pcw_pkg::SOFT_PARAM_PFH);
      end
   end

   // handler request, cold start and history entry
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         soft_armed  <= 1'b0;
         handler_req <= 1'b0;
         cold_start  <= 1'b0;
         hist        <= '0;
      end else begin
         soft_armed  <= (next_state == pcw_pkg::PCW_ARMED);
         handler_req <= (next_state == pcw_pkg::PCW_HANDLER);
         cold_start  <= (next_state == pcw_pkg::PCW_RESTART);
         hist.valid  <= 1'b0;
         hist.cause  <= pcw_pkg::CAUSE_NONE;
         // soft expiry entry wins over a supply entry in the same cycle
         if (state == pcw_pkg::PCW_ARMED && next_state == pcw_pkg::PCW_HANDLER) begin
            hist.valid <= 1'b1;
            hist.cause <= pcw_pkg::CAUSE_SOFT_WDOG;
         end else if (fault_rise) begin
            hist.valid <= 1'b1; // supply fault only logs an entry; no handler request
            hist.cause <= pcw_pkg::CAUSE_SUPPLY;
         end
      end
   end

   // hardware watchdog checks
   lamp_follows_a: assert property (@(posedge clk) disable iff (!rst_b)
      watchdog_lamp == relay_on) else $error("lamp differs from relay");
   status_follows_a: assert property (@(posedge clk) disable iff (!rst_b)
      relay_status == relay_on) else $error("status differs from relay");
   kick_holds_a: assert property (@(posedge clk) disable iff (!rst_b)
      kick_edge |=> relay_on) else $error("relay off after kick edge");
   kick_drop_a: assert property (@(posedge clk) disable iff (!rst_b)
      (kick_expire && !kick_edge) |=> !relay_on) else $error("relay held past limit");
   edge_reload_a: assert property (@(posedge clk) disable iff (!rst_b)
      kick_edge |=> kick_cnt == '0) else $error("counter not reloaded");
   // a pin level left over from reset must not close the relay
   warm_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
      (!kick_warm[2] && kick_expire) |=> !relay_on) else $error("relay closed before kick");

   // soft watchdog checks
   arm_first_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state == pcw_pkg::PCW_IDLE && cmd_arm) |=> soft_armed) else $error("not armed");
   rearm_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state == pcw_pkg::PCW_ARMED && cmd_arm) |=> soft_armed && soft_cnt == '0)
      else $error("timer not re-triggered");
   disarm_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state == pcw_pkg::PCW_ARMED && cmd_off) |=> !soft_armed && !cold_start)
      else $error("disarm failed");
   disarm_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
      (!soft_armed && !handler_req) |=> !cold_start) else $error("cold start while disarmed");
   cold_expiry_a: assert property (@(posedge clk) disable iff (!rst_b)
      (soft_expire && !soft_pfh) |=> cold_start && !handler_req)
      else $error("no cold start on expiry");
   cold_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
      cold_start |=> !cold_start) else $error("cold start held too long");

   // handler and history checks
   pfh_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cmd_arm && soft_cmd.param == pcw_pkg::SOFT_PARAM_PFH) |=> soft_pfh)
      else $error("handler mode not kept");
   handler_first_a: assert property (@(posedge clk) disable iff (!rst_b)
      (soft_expire && soft_pfh) |=> handler_req && !cold_start && hist.valid
      && hist.cause == pcw_pkg::CAUSE_SOFT_WDOG) else $error("handler path wrong");
   handler_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
      (handler_req && !handler_done) |=> handler_req) else $error("handler wait dropped");
   handler_cold_a: assert property (@(posedge clk) disable iff (!rst_b)
      (handler_req && handler_done) |=> cold_start && !handler_req)
      else $error("no cold start after handler");
   supply_log_a: assert property (@(posedge clk) disable iff (!rst_b)
      (fault_rise && !(soft_expire && soft_pfh)) |=> hist.valid
      && hist.cause == pcw_pkg::CAUSE_SUPPLY) else $error("supply not logged");

endmodule : pcw_watchdog

// File: hdl/pcw_pkg.sv
package pcw_pkg;

   // clock rate and watchdog intervals
   localparam int unsigned CLK_HZ          = 200_000_000;
   localparam int unsigned KICK_LIMIT_MS   = 200;
   localparam int unsigned SOFT_LIMIT_MS   = 200;
   // longest allowed gap, rounded down to whole cycles
   localparam int unsigned KICK_LIMIT_CYC  = (CLK_HZ / 1000) * KICK_LIMIT_MS;
   localparam int unsigned SOFT_LIMIT_CYC  = (CLK_HZ / 1000) * SOFT_LIMIT_MS;
   localparam int unsigned CNT_W           = 32;

   // soft watchdog command parameter values
   localparam logic [1:0] SOFT_PARAM_OFF   = 2'h0;
   localparam logic [1:0] SOFT_PARAM_COLD  = 2'h1;
   localparam logic [1:0] SOFT_PARAM_PFH   = 2'h2;

   // history cause codes
   localparam logic [1:0] CAUSE_NONE       = 2'h0;
   localparam logic [1:0] CAUSE_SOFT_WDOG  = 2'h1;
   localparam logic [1:0] CAUSE_SUPPLY     = 2'h2;

   // soft watchdog states
   typedef enum logic [1:0] {
      PCW_IDLE,
      PCW_ARMED,
      PCW_HANDLER,
      PCW_RESTART
   } pcw_state_t;

   // command from the cpu side
   typedef struct packed {
      logic       valid;
      logic [1:0] param;
   } pcw_cmd_t;

   // history entry
   typedef struct packed {
      logic       valid;
      logic [1:0] cause;
   } pcw_hist_t;

endpackage : pcw_pkg

// File: tb/pcw_safety_model.sv
`timescale 1ns/1ps
// installation safety circuit behind the relay contact
module pcw_safety_model (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic relay_on,
   output logic      plant_enabled
);
   // plant runs only while the contact is closed; a dropped contact trips it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) plant_enabled <= 1'b0;
      else        plant_enabled <= relay_on;
   end
endmodule : pcw_safety_model

// File: tb/test_pcw_watchdog.sv
`timescale 1ns/1ps
module test_pcw_watchdog;
   typedef struct packed {
      logic              kick;
      pcw_pkg::pcw_cmd_t cmd;
      logic              relay;
      logic              armed;
   } pcw_row_t;
   logic              clk, rst_b, kick, supply_fault, handler_done, plant;
   pcw_pkg::pcw_cmd_t soft_cmd;
   pcw_pkg::pcw_hist_t hist;
   logic              relay_on, watchdog_lamp, relay_status, soft_armed;
   logic              handler_req, cold_start;
   int                bad_count, n_compared, i;
   pcw_row_t          rows [6];
   pcw_watchdog dut (.clk(clk), .rst_b(rst_b), .kick(kick), .soft_cmd(soft_cmd),
      .supply_fault(supply_fault), .handler_done(handler_done), .relay_on(relay_on),
      .watchdog_lamp(watchdog_lamp), .relay_status(relay_status),
      .soft_armed(soft_armed), .handler_req(handler_req), .cold_start(cold_start),
      .hist(hist));
   pcw_safety_model partner (.clk(clk), .rst_b(rst_b), .relay_on(relay_on),
      .plant_enabled(plant));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task check(input logic [3:0] got, input logic [3:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask : check
   task results;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results
   // outputs grouped as relay, lamp, status, armed
   function automatic logic [3:0] outs;
      return {relay_on, watchdog_lamp, relay_status, soft_armed};
   endfunction : outs
   initial begin
      // program toggles kick well inside the limit, as a long cycle must
      rows[0] = {1'b1, 3'h0, 1'b1, 1'b0};
      rows[1] = {1'b1, 3'h5, 1'b1, 1'b1};
      rows[2] = {1'b0, 3'h6, 1'b1, 1'b1};
      rows[3] = {1'b0, 3'h7, 1'b1, 1'b1};
      rows[4] = {1'b1, 3'h4, 1'b1, 1'b0};
      rows[5] = {1'b1, 3'h4, 1'b1, 1'b0};
      rst_b = 1'b0;
      kick = 1'b0;
      supply_fault = 1'b0;
      handler_done = 1'b0;
      soft_cmd = '0;
      bad_count = 0;
      n_compared = 0;
      repeat (10) @(posedge clk);
      #1 check(outs(), 4'h0);
      rst_b = 1'b1;
      repeat (8) @(posedge clk);
      #1 check(outs(), 4'h0);
      $display("reset test done");
      // table: kick edges and soft commands
      for (i = 0; i < 6; i++) begin
         @(posedge clk);
         #1 kick = rows[i].kick;
         soft_cmd = rows[i].cmd;
         @(posedge clk);
         #1 soft_cmd = '0;
         repeat (6) @(posedge clk);
         #1 check(outs(), {{3{rows[i].relay}}, rows[i].armed});
         check({3'h0, cold_start | handler_req}, 4'h0);
         check({3'h0, plant}, {3'h0, rows[i].relay});
      end
      $display("table test done");
      // supply fault logs a history entry with its own cause
      supply_fault = 1'b1;
      for (i = 0; i < 20 && hist.valid !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      check({1'b0, hist}, {2'h1, pcw_pkg::CAUSE_SUPPLY});
      if (i == 20) bad_count++;
      $display("supply fault test done");
      // mid-run reset drops relay and lamp
      @(posedge clk);
      #1 rst_b = 1'b0;
      #1 check(outs(), 4'h0);
      // kick pin stays high through reset: no edge, relay stays open
      @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (6) @(posedge clk);
      #1 check(outs(), 4'h0);
      kick = 1'b0;
      repeat (6) @(posedge clk);
      #1 check(outs(), 4'hE);
      check({3'h0, plant}, 4'h1);
      $display("second reset test done");
      results();
   end
endmodule : test_pcw_watchdog
